// ===== hdl/twc_pkg.sv
// Shared constants for the two-wire memory bus controller: register map,
// field positions, command codes, engine states and timing counts.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM slave port.
package twc_pkg;

	// Byte addresses of the controller's own registers.
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CMD    = 4'h4;
	localparam logic [3:0] REG_CFG    = 4'h8;

	// Status register fields.
	localparam int unsigned STS_BUSY_BIT   = 0;
	localparam int unsigned STS_NACK_BIT   = 1;
	localparam int unsigned STS_ACTIVE_BIT = 2;
	localparam int unsigned STS_RX_LSB     = 8;

	// Command register fields.
	localparam int unsigned CMD_DATA_LSB = 0;
	localparam int unsigned CMD_OP_LSB   = 8;
	localparam int unsigned CMD_NACK_BIT = 11;
	localparam int unsigned CMD_RW_BIT   = 12;

	// Configuration register fields; everything resets to zero.
	localparam int unsigned CFG_STRAP_LSB = 0;
	localparam int unsigned CFG_WP_BIT    = 3;

	// Fixed upper nibble of every device address word.
	localparam logic [3:0] DEV_FAMILY = 4'ha;

	// Index of the last bit of a transferred word, the acknowledge slot; a word is nine bits.
	localparam logic [3:0] LAST_BIT = 4'h8;

	// Timing: system clock period and the serial clock period we generate.
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SCL_PERIOD_NS = 10000;
	localparam int unsigned QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int unsigned DIV_W         = 8;

	// Commands that software writes into the command register.
	typedef enum logic [2:0] {
		OP_NONE    = 3'h0,
		OP_START   = 3'h1,
		OP_STOP    = 3'h2,
		OP_WRITE   = 3'h3,
		OP_READ    = 3'h4,
		OP_ADDR    = 3'h5,
		OP_RECOVER = 3'h6
	} twc_op_e;

	// Bus engine states; every code is used.
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_BIT   = 2'b10,
		ST_STOP  = 2'b11
	} twc_state_e;

endpackage : twc_pkg

// ===== hdl/twc_tick.sv
// Quarter-bit enable generator for the two-wire bus controller.
// Assumes one system clock; the enable is a one-cycle pulse every DIV cycles.
module twc_tick
	import twc_pkg::*;
#(
	parameter int unsigned DIV = QUARTER_CYC
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	output logic      tick_o
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} twc_tick_s;

	twc_tick_s r_reg;
	twc_tick_s r_next;

	// Free-running divider; phases need no alignment to software requests.
	always_comb begin
		r_next      = r_reg;
		r_next.tick = 1'b0;
		if (r_reg.cnt == DIV_W'(DIV - 1)) begin
			r_next.cnt  = '0;
			r_next.tick = 1'b1;
		end else begin
			r_next.cnt = r_reg.cnt + 1'b1;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tick_o = r_reg.tick;

endmodule // twc_tick

// ===== hdl/twc_host.sv
// Two-wire bus controller that drives a serial byte memory through its
// clock, data and write-protect pins, steered by software over Avalon-MM.
// Assumes an external pull-up on the data wire and that the memory never
// stretches the clock; the data pin is open-drain (output, enable, input).
// What the memory's document requires (device-side rules are kept by the memory, not this block)
// R1 - Data changes only while clock low
// R2 - Start: data falls while clock high
// R3 - Stop: data rises while clock high
// R4 - Device acknowledges each byte in ninth clock
// R5 - Device idles after power-up and stop
// R6 - Recover: start, nine clocks, start, stop
// R7 - Device write time is a busy duration
// R8 - Address word begins with fixed family pattern
// R9 - Next three bits match the strap pins
// R10 - Last address bit: one reads, zero writes
// R11 - Mismatched address gets no acknowledge
// R12 - Write-protect high blocks all programming
// R13 - Write sends two address bytes, then data
// R14 - Device ignores bus while programming
// R15 - Page write: up to 128 data bytes
// R16 - Write address wraps within its page
// R17 - Poll with address until device acknowledges
// R18 - Device keeps address counter plus one
// R19 - Read address wraps at top of memory
// R20 - Current read: controller gives no acknowledge
// R21 - Random read: dummy write, repeated start
// R22 - Acknowledged reads continue; no acknowledge ends
// R23 - Sixteen-bit address, high byte first
// R24 - Write-protect low allows writes
// R25 - Protected writes still acknowledged, no busy
// R26 - Device samples on rise, changes after fall
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
module twc_host
	import twc_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic             scl_o,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        sda_i,
	output logic             wp_o
);

	typedef struct packed {
		twc_state_e  state;
		logic [1:0]  phase;
		logic [3:0]  bitcnt;
		logic [8:0]  tx;
		logic [8:0]  rx;
		twc_op_e     op;
		logic        rec_on;
		logic [1:0]  rec_stage;
		logic        busy;
		logic        scl;
		logic        sda_oe;
		logic        sda_lo;
		logic [2:0]  sync;
		logic        sda_in;
		logic [2:0]  chip_select_strap;
		logic        wp;
		logic        av_wait;
		logic [31:0] rdata;
	} twc_host_s;

	localparam twc_host_s RST_VAL = '{
		state:   ST_IDLE,
		op:      OP_NONE,
		scl:     1'b1,
		sda_in:  1'b1,
		sync:    3'b111, // Idle wire level, so no false low follows reset.
		av_wait: 1'b1,
		default: '0
	};

	twc_host_s  r_reg;
	twc_host_s  r_next;
	logic       tick;
	logic [31:0] rd_word;
	twc_op_e    cmd_op;

	// Quarter-bit pacing; each bus phase lasts one tick.
	twc_tick #(
		.DIV (QUARTER_CYC)
	) u_tick (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.tick_o    (tick)
	);

	// Register read mux and command decode.
	always_comb begin
		rd_word = '0;
		unique case (avs_address_i)
			REG_STATUS: begin
				rd_word[STS_BUSY_BIT]        = r_reg.busy;
				rd_word[STS_NACK_BIT]        = r_reg.rx[0];
				rd_word[STS_ACTIVE_BIT]      = ~r_reg.scl;
				rd_word[STS_RX_LSB +: 8]     = r_reg.rx[8:1];
			end
			REG_CFG: begin
				rd_word[CFG_STRAP_LSB +: 3] = r_reg.chip_select_strap;
				rd_word[CFG_WP_BIT]         = r_reg.wp;
			end
			default: rd_word = '0;
		endcase
		cmd_op = twc_op_e'(avs_writedata_i[CMD_OP_LSB +: 3]);
	end

	// Next-state logic: bus slave, command loader and bit engine.
	always_comb begin
		r_next         = r_reg;
		r_next.av_wait = 1'b1;
		// Three-stage sampler; the stored level moves only when the last two agree.
		r_next.sync = {r_reg.sync[1:0], sda_i};
		if (r_reg.sync[1] == r_reg.sync[2]) begin
			r_next.sda_in = r_reg.sync[2];
		end

		// One wait state for every access; command writes stall while busy.
		if (avs_read_i && r_reg.av_wait) begin
			r_next.av_wait = 1'b0;
			r_next.rdata   = rd_word;
		end else if (avs_write_i && r_reg.av_wait) begin
			if (avs_address_i == REG_CFG) begin
				r_next.av_wait           = 1'b0;
				r_next.chip_select_strap = avs_writedata_i[CFG_STRAP_LSB +: 3];
				r_next.wp                = avs_writedata_i[CFG_WP_BIT]; // R12 R24
			end else if (avs_address_i != REG_CMD) begin
				r_next.av_wait = 1'b0;
			end else if (!r_reg.busy) begin
				r_next.av_wait = 1'b0;
				r_next.phase   = 2'h0;
				r_next.bitcnt  = '0;
				r_next.op      = cmd_op;
				r_next.busy    = 1'b1;
				r_next.rec_on  = 1'b0;
				unique case (cmd_op)
					OP_START: r_next.state = ST_START; // R2 R21
					OP_RECOVER: begin
						r_next.state     = ST_START; // R6
						r_next.rec_on    = 1'b1;
						r_next.rec_stage = 2'h0;
					end
					OP_STOP, OP_WRITE, OP_READ, OP_ADDR: begin
						// A free bus has clock high; any data move now would
						// fake a start or stop, so only a start may come first.
						if (r_reg.scl) begin
							r_next.busy = 1'b0; // R1 R2
						end else if (cmd_op == OP_STOP) begin
							r_next.state = ST_STOP; // R3
						end else begin
							r_next.state = ST_BIT;
						end
					end
					default: r_next.busy = 1'b0;
				endcase
				unique case (cmd_op)
					OP_WRITE: r_next.tx = {avs_writedata_i[CMD_DATA_LSB +: 8], 1'b1}; // R13 R15
					OP_READ: r_next.tx = {8'hff, avs_writedata_i[CMD_NACK_BIT]}; // R20 R22
					OP_ADDR: begin
						r_next.tx = {DEV_FAMILY, r_reg.chip_select_strap,
							avs_writedata_i[CMD_RW_BIT], 1'b1}; // R8 R9 R10 R17
					end
					default: r_next.tx = r_reg.tx;
				endcase
			end
		end

		// Bus engine advances one phase per tick.
		if (tick && r_reg.state != ST_IDLE) begin
			r_next.phase = r_reg.phase + 2'h1;
			unique case (r_reg.state)
				ST_START: begin
					unique case (r_reg.phase)
						2'h0: r_next.sda_oe = 1'b0;
						2'h1: r_next.scl = 1'b1;
						2'h2: r_next.sda_oe = 1'b1; // R2
						2'h3: r_next.scl = 1'b0;
					endcase
				end
				ST_BIT: begin
					unique case (r_reg.phase)
						2'h0: r_next.sda_oe = ~r_reg.tx[8]; // R1
						2'h1: r_next.scl = 1'b1;
						// Sample mid-high: the memory changes data only after a fall.
						2'h2: r_next.rx = {r_reg.rx[7:0], r_reg.sda_in}; // R4 R26
						2'h3: begin
							r_next.scl    = 1'b0;
							r_next.tx     = {r_reg.tx[7:0], 1'b1};
							r_next.bitcnt = r_reg.bitcnt + 4'h1;
						end
					endcase
				end
				ST_STOP: begin
					unique case (r_reg.phase)
						2'h0: r_next.sda_oe = 1'b1;
						2'h1: r_next.scl = 1'b1;
						2'h2: r_next.sda_oe = 1'b0; // R3
						2'h3: r_next.scl = 1'b1;
					endcase
				end
				ST_IDLE: r_next.phase = r_reg.phase;
			endcase

			// End of a step: hand over to the next recovery stage or go idle.
			if (r_reg.phase == 2'h3 && (r_reg.state != ST_BIT || r_reg.bitcnt == LAST_BIT)) begin
				r_next.state = ST_IDLE;
				r_next.busy  = 1'b0;
				if (r_reg.rec_on) begin
					r_next.busy      = 1'b1;
					r_next.rec_stage = r_reg.rec_stage + 2'h1;
					r_next.bitcnt    = '0;
					unique case (r_reg.rec_stage)
						2'h0: begin
							r_next.state = ST_BIT; // R6
							r_next.tx    = '1;
						end
						2'h1: r_next.state = ST_START; // R6
						2'h2: r_next.state = ST_STOP; // R6
						2'h3: begin
							r_next.rec_on = 1'b0;
							r_next.busy   = 1'b0;
						end
					endcase
				end
			end
		end
	end

	// Single state register; synchronous reset releases the bus.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r_reg <= RST_VAL;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs come straight from the state register.
	assign avs_readdata_o    = r_reg.rdata;
	assign avs_waitrequest_o = r_reg.av_wait;
	assign scl_o             = r_reg.scl;
	assign sda_o             = r_reg.sda_lo;
	assign sda_oe_o          = r_reg.sda_oe;
	assign wp_o              = r_reg.wp;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	// Data may move under a high clock only inside start or stop steps.
	a_sda_stable_high: assert property ( // R1
		(r_reg.scl && $past(r_reg.scl) && (r_reg.sda_oe != $past(r_reg.sda_oe)))
		|-> ($past(r_reg.state) inside {ST_START, ST_STOP})
	) else $error("data moved while clock high outside start or stop");

	a_start_shape: assert property ( // R2
		(r_reg.scl && $past(r_reg.scl) && $rose(r_reg.sda_oe))
		|-> ($past(r_reg.state) == ST_START && $past(r_reg.phase) == 2'h2)
	) else $error("data fell under high clock without a start step");

	a_stop_shape: assert property ( // R3
		(r_reg.scl && $past(r_reg.scl) && $fell(r_reg.sda_oe))
		|-> ($past(r_reg.state) == ST_STOP) ##1 (r_reg.scl && !r_reg.sda_oe)
	) else $error("data rose under high clock without a stop step");

	a_addr_family: assert property ( // R8
		(r_reg.state == ST_BIT && r_reg.op == OP_ADDR && $past(r_reg.state) == ST_IDLE)
		|-> (r_reg.tx[8:5] == DEV_FAMILY && r_reg.tx[4:2] == r_reg.chip_select_strap)
	) else $error("address word lacks family pattern or strap bits");

	a_addr_dir_bit: assert property ( // R10
		(r_reg.state == ST_BIT && r_reg.op == OP_ADDR && $past(r_reg.state) == ST_IDLE)
		|-> (r_reg.tx[1] == $past(avs_writedata_i[CMD_RW_BIT]) && r_reg.tx[0])
	) else $error("direction bit of address word wrong");

	a_nine_bit_word: assert property ( // R4
		($past(r_reg.state) == ST_BIT && r_reg.state != ST_BIT && !r_reg.rec_on)
		|-> ($past(r_reg.bitcnt) == LAST_BIT && !r_reg.scl)
	) else $error("word did not span exactly nine clocks");

	a_read_release: assert property ( // R20
		(r_reg.state == ST_BIT && r_reg.op == OP_READ && r_reg.bitcnt < LAST_BIT && r_reg.scl)
		|-> !r_reg.sda_oe
	) else $error("controller drove data while the memory sends");

	a_read_ack: assert property ( // R22
		(r_reg.state == ST_BIT && r_reg.op == OP_READ && r_reg.bitcnt == LAST_BIT && r_reg.scl)
		|-> (r_reg.sda_oe == ~r_reg.tx[8]) ##1 (r_reg.sda_oe == $past(r_reg.sda_oe))
	) else $error("acknowledge slot of a read not driven as ordered");

	a_recover_clocks: assert property ( // R6
		(r_reg.rec_on && r_reg.state == ST_BIT && r_reg.scl) |-> !r_reg.sda_oe
	) else $error("recovery clocks drove data low");

	a_read_answer: assert property (
		(avs_read_i && r_reg.av_wait) |-> ##1 (!r_reg.av_wait && r_reg.rdata == $past(rd_word))
	) else $error("register read not answered in one cycle");

	c_stop_done: cover property (r_reg.state == ST_STOP ##1 r_reg.state == ST_IDLE);
	c_read_done: cover property (r_reg.op == OP_READ && $fell(r_reg.busy));
	c_recover_done: cover property ($fell(r_reg.rec_on));
	c_cmd_accepted: cover property (avs_write_i && !r_reg.av_wait && avs_address_i == REG_CMD);

endmodule // twc_host

// ===== verif/twc_mem_model.sv
// Behavioural serial byte memory answering the controller on its pins.
// Assumes the bench resolves the open-drain data wire and feeds it back.
module twc_mem_model #(
	parameter logic [2:0] STRAP   = 3'h5,
	parameter int         BUSY_NS = 150000
) (
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic wp_i,
	output logic      pull_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [0:65535];
	logic [15:0] ptr;
	logic [7:0]  sh;
	logic [7:0]  rd;
	int          bits;
	int          st;
	bit          busy;
	bit          wrote;
	bit          ack;

	// Known contents, so reads of unwritten places can be predicted.
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
		{pull_o, busy, wrote, ack} = '0;
		st = 5;
		bits = 0;
		ptr = '0;
	end
	// Start: data falls with clock high; deaf while programming.
	always @(negedge sda_i) if (scl_i && !busy) begin
		st = 0;
		bits = 0;
		wrote = 0;
	end
	// Stop ends the frame; an unprotected write then runs its busy time.
	always @(posedge sda_i) if (scl_i && !busy) begin
		st = 5;
		if (wrote && !wp_i) begin
			busy = 1;
			#(BUSY_NS) busy = 0;
		end
	end
	// Sample on the rising clock; a word is decoded at its eighth bit.
	always @(posedge scl_i) if (st < 5 && !busy) begin
		if (bits < 8)
			sh = {sh[6:0], sda_i};
		if (bits == 8 && st == 4 && sda_i)
			st = 5;
		bits = (bits == 8) ? 0 : bits + 1;
		if (bits == 8) begin
			ack = (st != 4);
			// All decoding sits in this one process, so no two edge processes race.
			case (st)
				0: st = (sh[7:1] == {4'ha, STRAP}) ? (sh[0] ? 4 : 1) : 5;
				1: begin
					ptr[15:8] = sh;
					st = 2;
				end
				2: begin
					ptr[7:0] = sh;
					st = 3;
				end
				3: begin
					// Data bytes; the write pointer wraps inside its page.
					if (!wp_i)
						mem[ptr] = sh;
					wrote = 1;
					ptr[6:0] = ptr[6:0] + 7'h1;
				end
				default: ;
			endcase
			if (st == 5)
				ack = 0;
		end
	end
	// Drive only after the falling clock: acknowledge or next read bit.
	always @(negedge scl_i) begin
		if (st < 5 && !busy && bits == 8)
			pull_o = ack;
		else if (st == 4 && !busy) begin
			if (bits == 0) begin
				rd = mem[ptr];
				ptr = ptr + 16'h1;
			end
			pull_o = ~rd[7 - bits];
		end else
			pull_o = 0;
	end
endmodule // twc_mem_model

// ===== verif/test_twc_host.sv
// Self-checking bench: command sequences drive the controller against a
// behavioural memory; expectations come from local functions.
module test_twc_host
	import twc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [2:0] STRAP = 3'h5;
	logic        ref_clk_i = 0;
	logic        rst_i     = 1;
	logic [3:0]  addr      = '0;
	logic        rd_req    = 0;
	logic        wr_req    = 0;
	logic [31:0] wdata     = '0;
	logic [31:0] rdata;
	logic        waitreq;
	logic        scl;
	logic        sda_oe;
	logic        sda_lvl;
	logic        wp;
	logic        pull;
	wire         sda       = ~(sda_oe | pull);
	logic [31:0] sts;
	logic [7:0]  dat [4];
	logic [15:0] base;
	int          bad_count = 0;
	int          n_tests   = 0;
	int          seed      = 32'h434c;
	int          k;

	always #25 ref_clk_i = ~ref_clk_i;

	twc_host i_twc_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(addr),
		.avs_read_i(rd_req), .avs_write_i(wr_req), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .scl_o(scl), .sda_o(sda_lvl),
		.sda_oe_o(sda_oe), .sda_i(sda), .wp_o(wp));
	twc_mem_model #(.STRAP(STRAP)) i_twc_mem_model (.scl_i(scl), .sda_i(sda), .wp_i(wp),
		.pull_o(pull));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_bit(string nm, logic e, logic g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One Avalon transfer; waitrequest and read data are taken at the rising edge.
	task automatic bus(bit w, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge ref_clk_i);
		addr <= a;
		wr_req <= w;
		rd_req <= !w;
		wdata <= d;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (waitreq !== 1'b0 && n < 10000);
		q = rdata;
		wr_req <= 0;
		rd_req <= 0;
		if (n >= 10000) begin
			bad_count++;
			finish_test();
		end
	endtask
	// Issue a command, then poll until the engine is done; status kept in sts.
	task automatic cmd(twc_op_e op, logic [7:0] d = 8'h0, bit nk = 0, bit dir = 0);
		logic [31:0] q;
		int n;
		bus(1, REG_CMD, {19'h0, dir, nk, op, d}, q);
		n = 0;
		do begin
			bus(0, REG_STATUS, 0, sts);
			n++;
		end while (sts[STS_BUSY_BIT] !== 1'b0 && n < 2000);
		if (n >= 2000) begin
			bad_count++;
			finish_test();
		end
	endtask
	task automatic open_dev(bit dir);
		cmd(OP_START);
		cmd(OP_ADDR, 8'h0, 0, dir);
	endtask
	// Two address bytes, high first, each acknowledged.
	task automatic set_addr(logic [15:0] a);
		cmd(OP_WRITE, a[15:8]);
		chk_bit("ack hi", 0, sts[STS_NACK_BIT]);
		cmd(OP_WRITE, a[7:0]);
		chk_bit("ack lo", 0, sts[STS_NACK_BIT]);
	endtask
	task automatic rd_byte(bit nk, logic [7:0] e);
		cmd(OP_READ, 8'h0, nk);
		chk_word("read", {24'h0, e}, {24'h0, sts[15:8]});
	endtask
	function automatic logic [7:0] iv(logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction

	initial begin
		logic [31:0] q;
		logic [2:0]  s;
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 0;
		chk_bit("scl idle", 1, scl);
		chk_bit("sda idle", 0, sda_oe);
		chk_bit("sda level", 0, sda_lvl);
		chk_bit("wp reset", 0, wp);
		bus(0, REG_CFG, 0, q);
		chk_word("cfg reset", 0, q);
		bus(0, 4'hc, 0, q);
		chk_word("unmapped", 0, q);
		bus(1, REG_CFG, {29'h0, STRAP}, q);
		cmd(twc_op_e'(3'h0));
		cmd(twc_op_e'(3'h7));
		cmd(OP_STOP);
		chk_bit("free bus", 0, sts[STS_ACTIVE_BIT]);
		// Page write from offset 7e: the last two bytes wrap to the page start.
		k = $random(seed);
		base = {2'b01, k[6:0], 7'h0};
		open_dev(0);
		chk_bit("ack dev", 0, sts[STS_NACK_BIT]);
		set_addr(base + 16'h7e);
		for (int i = 0; i < 4; i++) begin
			dat[i] = 8'($random(seed));
			cmd(OP_WRITE, dat[i]);
			chk_bit("ack data", 0, sts[STS_NACK_BIT]);
		end
		cmd(OP_STOP);
		// Polling is refused while programming, then the random read goes on.
		open_dev(0);
		chk_bit("busy nack", 1, sts[STS_NACK_BIT]);
		for (k = 0; k < 20 && sts[STS_NACK_BIT] !== 1'b0; k++)
			open_dev(0);
		chk_bit("poll ack", 0, sts[STS_NACK_BIT]);
		set_addr(base + 16'h7e);
		open_dev(1);
		rd_byte(0, dat[0]);
		rd_byte(1, dat[1]);
		cmd(OP_STOP);
		open_dev(1);
		rd_byte(1, iv(base + 16'h80));
		cmd(OP_STOP);
		open_dev(0);
		set_addr(base);
		open_dev(1);
		rd_byte(0, dat[2]);
		rd_byte(1, dat[3]);
		cmd(OP_STOP);
		open_dev(0);
		set_addr(16'hffff);
		open_dev(1);
		rd_byte(0, iv(16'hffff));
		rd_byte(1, iv(16'h0));
		cmd(OP_STOP);
		// Only a matching strap value is acknowledged.
		for (int i = 0; i < 4; i++) begin
			s = (i == 0) ? STRAP : STRAP ^ (3'($random(seed)) | 3'h1);
			bus(1, REG_CFG, {29'h0, s}, q);
			open_dev(0);
			chk_bit("strap", s != STRAP, sts[STS_NACK_BIT]);
			cmd(OP_STOP);
		end
		// Protected write: acknowledged, no busy time, contents kept.
		bus(1, REG_CFG, {28'h1, STRAP}, q);
		bus(0, REG_CFG, 0, q);
		chk_word("cfg", {28'h1, STRAP}, q);
		chk_bit("wp pin", 1, wp);
		open_dev(0);
		set_addr(base + 16'h10);
		cmd(OP_WRITE, ~iv(base + 16'h10));
		chk_bit("wp ack", 0, sts[STS_NACK_BIT]);
		cmd(OP_STOP);
		open_dev(0);
		chk_bit("wp idle", 0, sts[STS_NACK_BIT]);
		set_addr(base + 16'h10);
		open_dev(1);
		rd_byte(1, iv(base + 16'h10));
		cmd(OP_STOP);
		// An interrupted write, then recovery leaves the device ready.
		bus(1, REG_CFG, {29'h0, STRAP}, q);
		open_dev(0);
		cmd(OP_WRITE, 8'h00);
		cmd(OP_RECOVER);
		chk_bit("rec free", 0, sts[STS_ACTIVE_BIT]);
		open_dev(0);
		chk_bit("rec ack", 0, sts[STS_NACK_BIT]);
		cmd(OP_STOP);
		// A reset in mid-frame must return pins and configuration to idle.
		bus(1, REG_CFG, {28'h1, STRAP}, q);
		cmd(OP_START);
		rst_i <= 1;
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 0;
		@(posedge ref_clk_i);
		chk_bit("scl after reset", 1, scl);
		chk_bit("sda after reset", 0, sda_oe);
		chk_bit("sda level after reset", 0, sda_lvl);
		chk_bit("wp after reset", 0, wp);
		chk_word("rdata after reset", 0, rdata);
		bus(0, REG_CFG, 0, q);
		chk_word("cfg after reset", 0, q);
		finish_test();
	end
endmodule // test_twc_host
